// ===== dv/agt_angle_trim_tb.sv
// self-checking bench of the angle and gain trim readout
// assumes the sample source model and the register offsets header
`timescale 1ns/1ps
`include "agt_regs.svh"

module agt_angle_trim_tb;
   import agt_pkg::*;

   logic               clk;
   logic               rst_n;
   logic               go;
   logic               sv;
   logic               reg_wr;
   logic               reg_rd;
   logic               alert;
   logic               irq;
   logic [7:0]         reg_addr;
   logic [15:0]        reg_wdata;
   logic [15:0]        reg_rdata;
   logic [15:0]        d;
   logic signed [15:0] sx;
   logic signed [15:0] sy;
   logic signed [15:0] sz;
   agt_axes_t          sample;
   int                 n_errors;
   int                 n_tests;
   int                 cyc;
   int                 na;

   agt_sample_src i_src (.CLK(clk), .GO(go), .X(sx), .Y(sy), .Z(sz),
      .SAMPLE(sample), .SAMPLE_VALID(sv));

   agt_angle_trim i_dut (.CLK(clk), .RST_N(rst_n), .SAMPLE_VALID(sv),
      .SAMPLE(sample), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
      .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
      .ALERT(alert), .IRQ(irq));

   // ********************************
   // clock and hang guard
   // ********************************
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_errors++;
         results();
      end
   end

   // ********************************
   // bus, conversion and compare tasks
   // ********************************
   task automatic wr(input logic [7:0] a, input logic [15:0] v);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= v;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [15:0] v);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask : rd

   task automatic kick(input int x, input int y, input int z);
      @(posedge clk);
      sx <= 16'(x);
      sy <= 16'(y);
      sz <= 16'(z);
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
   endtask : kick

   // counts alert cycles until the conversion surely ended
   task automatic finish(output int n);
      n = 0;
      repeat (25) begin
         @(posedge clk);
         #1 if (alert === 1'b1) n++;
      end
   endtask : finish

   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // angle of (first, second) in sixteenths, two steps of slack
   task automatic chk_ang(input string nm, input real f, input real s,
                          input logic [15:0] g);
      real a;
      int  e;
      int  df;
      a = $atan2(s, f) * 180.0 / 3.14159265358979;
      if (a < 0.0) a = a + 360.0;
      e  = int'(a * 16.0) % 5760;
      df = (int'(g) - e + 5760) % 5760;
      n_tests++;
      if ($isunknown(g) || g >= 16'h1680 || (df > 2 && df < 5758)) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, 16'(e), g);
      end
   endtask : chk_ang

   // host calibration: span ratio to trim axis and value
   function automatic logic [11:0] trim_of(input real ax, input real ay);
      real g;
      g = ay / ax;
      if (g == 1.0) return {2'b00, 10'h000};
      if (g > 1.0) return {2'b10, 10'(int'(1024.0 / g))};
      return {2'b01, 10'(int'(g * 1024.0))};
   endfunction : trim_of

   // ********************************
   // scenarios
   // ********************************
   task automatic t_reset();
      for (int i = 0; i < 8; i++) begin
         rd(8'(4 * i), d);
         chk("reset value", 16'h0000, d);
      end
      $display("test reset done");
   endtask : t_reset

   task automatic t_pairs();
      int  p[5] = '{0, 1, 2, 0, 0};
      int  x[5] = '{300, 300, 300, 1000, -500};
      int  y[5] = '{-400, -400, -400, -1, 0};
      int  z[5] = '{500, 500, 500, 0, 0};
      real f;
      real s;
      for (int i = 0; i < 5; i++) begin
         wr(`AGT_A_ANG_CFG, 16'h0004 | 16'(p[i]));
         kick(x[i], y[i], z[i]);
         finish(na);
         chk("alert pulse", 16'h0001, 16'(na));
         chk("irq masked", 16'h0000, {15'h0000, irq});
         rd(`AGT_A_ANGLE, d);
         f = (p[i] == 1) ? y[i] : x[i];
         s = (p[i] == 0) ? y[i] : z[i];
         chk_ang("angle", f, s, d);
      end
      $display("test pairs done");
   endtask : t_pairs

   task automatic t_trim();
      real         ax[3] = '{60000.0, 45000.0, 60000.0};
      real         ay[3] = '{45000.0, 60000.0, 60000.0};
      logic [11:0] g;
      int          t;
      wr(`AGT_A_ANG_CFG, 16'h0004);
      for (int i = 0; i < 3; i++) begin
         g = trim_of(ax[i], ay[i]);
         if (g[11:10] == 2'b00) g[9:0] = 10'h200;
         wr(`AGT_A_GAIN_CFG, {4'h0, g});
         rd(`AGT_A_GAIN_CFG, d);
         chk("trim setting", {4'h0, g}, d);
         kick(1000, 1000, 0);
         finish(na);
         rd(`AGT_A_ANGLE, d);
         t = (1000 * int'(g[9:0])) >>> 10;
         chk_ang("trimmed angle", (g[11:10] == 2'b01) ? t : 1000,
                 (g[11:10] == 2'b10) ? t : 1000, d);
      end
      $display("test trim done");
   endtask : t_trim

   task automatic t_timing();
      wr(`AGT_A_GAIN_CFG, 16'h0000);
      wr(`AGT_A_ANG_CFG, 16'h0000);
      wr(`AGT_A_INT_STAT, 16'h0003);
      wr(`AGT_A_INT_MASK, 16'h0001);
      #1 chk("irq cleared", 16'h0000, {15'h0000, irq});
      kick(1000, 0, 0);
      finish(na);
      chk("alert off", 16'h0000, 16'(na));
      kick(1000, 1000, 0);
      wr(`AGT_A_GAIN_CFG, 16'h0600);
      rd(`AGT_A_STATUS, d);
      chk("busy flag", 16'h0001, d);
      rd(`AGT_A_ANGLE, d);
      chk_ang("old angle", 1000.0, 0.0, d);
      kick(1, 1, 1);
      finish(na);
      chk("irq raised", 16'h0001, {15'h0000, irq});
      rd(`AGT_A_INT_STAT, d);
      chk("done and overrun", 16'h0003, d);
      rd(`AGT_A_ANGLE, d);
      chk_ang("trim too late", 1000.0, 1000.0, d);
      wr(`AGT_A_INT_STAT, 16'h0001);
      #1 chk("irq after clear", 16'h0000, {15'h0000, irq});
      rd(`AGT_A_INT_STAT, d);
      chk("overrun left", 16'h0002, d);
      kick(1000, 1000, 0);
      finish(na);
      rd(`AGT_A_ANGLE, d);
      chk_ang("trim applied", 500.0, 1000.0, d);
      $display("test timing done");
   endtask : t_timing

   // ********************************
   // verdict
   // ********************************
   task automatic results();
      $display("counts: %0d compares, %0d mismatches", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : results

   initial begin
      rst_n     = 1'b0;
      go        = 1'b0;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_addr  = 8'h00;
      reg_wdata = 16'h0000;
      sx        = 16'sh0000;
      sy        = 16'sh0000;
      sz        = 16'sh0000;
      n_errors  = 0;
      n_tests   = 0;
      cyc       = 0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_pairs();
      t_trim();
      t_timing();
      results();
   end
endmodule : agt_angle_trim_tb

// ===== dv/agt_sample_src.sv
// sample-set source standing in for the sensor front end
// assumes the bench raises GO for one cycle per wanted sample set
`timescale 1ns/1ps

module agt_sample_src (
   input  wire logic               CLK,
   input  wire logic               GO,
   input  wire logic signed [15:0] X,
   input  wire logic signed [15:0] Y,
   input  wire logic signed [15:0] Z,
   output agt_pkg::agt_axes_t      SAMPLE,
   output logic                    SAMPLE_VALID
);
   import agt_pkg::*;

   initial begin
      SAMPLE_VALID = 1'b0;
      SAMPLE       = '0;
   end

   // one set per request; data only hold in the valid cycle
   always @(posedge CLK) begin
      SAMPLE_VALID <= GO;
      if (GO) begin
         SAMPLE <= {X, Y, Z};
      end else begin
         SAMPLE <= ~SAMPLE; // idle data keep moving
      end
   end
endmodule : agt_sample_src

// ===== verilog/agt_angle_trim.sv
// angle calculator with a gain trim on one selected axis (x or y), result and interrupt registers
// assumes one synchronous sample set per conversion on SAMPLE_VALID
`timescale 1ns/1ps
`include "agt_regs.svh"

module agt_angle_trim (
   input  wire logic               CLK,
   input  wire logic               RST_N,
   input  wire logic               SAMPLE_VALID,
   input  wire agt_pkg::agt_axes_t SAMPLE,
   input  wire logic [7:0]         REG_ADDR,
   input  wire logic [15:0]        REG_WDATA,
   input  wire logic               REG_WR,
   input  wire logic               REG_RD,
   output logic [15:0]             REG_RDATA,
   output logic                    ALERT,
   output logic                    IRQ
);
   import agt_pkg::*;

   // ********************************
   // state
   // ********************************
   logic [1:0]         pair_sel, next_pair_sel;
   logic               alert_en, next_alert_en;
   agt_gain_t          gain_cfg, next_gain_cfg;
   agt_gain_t          act_gain, next_act_gain;
   logic               act_alert, next_act_alert;
   agt_state_t         state, next_state;
   logic [3:0]         iter, next_iter;
   logic signed [18:0] cx, next_cx;
   logic signed [18:0] cy, next_cy;
   logic signed [17:0] cz, next_cz;
   logic [15:0]        angle_result, next_angle_result;
   logic [15:0]        mag_result, next_mag_result;
   logic [1:0]         int_status, next_int_status;
   logic [1:0]         int_mask, next_int_mask;
   logic [15:0]        next_rdata;
   logic               next_alert, next_irq;

   // ********************************
   // combinational helpers
   // ********************************
   logic               accept, overrun;
   logic signed [26:0] px, py;
   logic signed [15:0] tx, ty, pa, pb;
   logic signed [18:0] dx, dy;
   logic signed [17:0] zz;
   logic [1:0]         set_int, clr_int;

   // arctangent of 2^-i in 1/256 degree
   function automatic logic [17:0] atan_step(input logic [3:0] i);
      unique case (i)
         4'h0: atan_step = 18'h0_2D00;
         4'h1: atan_step = 18'h0_1A91;
         4'h2: atan_step = 18'h0_0E09;
         4'h3: atan_step = 18'h0_0720;
         4'h4: atan_step = 18'h0_0394;
         4'h5: atan_step = 18'h0_01CA;
         4'h6: atan_step = 18'h0_00E5;
         4'h7: atan_step = 18'h0_0073;
         4'h8: atan_step = 18'h0_0039;
         4'h9: atan_step = 18'h0_001D;
         4'hA: atan_step = 18'h0_000E;
         4'hB: atan_step = 18'h0_0007;
         4'hC: atan_step = 18'h0_0004;
         4'hD: atan_step = 18'h0_0002;
         default: atan_step = 18'h0_0000;
      endcase
   endfunction : atan_step

   // ********************************
   // gain trim and axis pairing
   // ********************************
   // products of an axis with value/1024, always below full scale
   always_comb begin
      px = SAMPLE.x * $signed({1'b0, gain_cfg.value});
      py = SAMPLE.y * $signed({1'b0, gain_cfg.value});
      tx = SAMPLE.x;
      ty = SAMPLE.y;
      unique case (gain_cfg.axis)
         `AGT_TRIM_X: tx = px[25:`AGT_TRIM_SHIFT];
         `AGT_TRIM_Y: ty = py[25:`AGT_TRIM_SHIFT];
         default: ;
      endcase
   end

   // pick the two axes feeding the angle calculator
   always_comb begin
      unique case (pair_sel)
         `AGT_PAIR_YZ: begin
            pa = ty;
            pb = SAMPLE.z;
         end
         `AGT_PAIR_XZ: begin
            pa = tx;
            pb = SAMPLE.z;
         end
         default: begin
            pa = tx;
            pb = ty;
         end
      endcase
   end

   // ********************************
   // next values
   // ********************************
   always_comb begin
      accept = SAMPLE_VALID && (state == AGT_IDLE);
      overrun = SAMPLE_VALID && (state != AGT_IDLE);
      dx = cx >>> iter;
      dy = cy >>> iter;
      zz = cz;
      if (cz[17]) begin
         zz = cz + `AGT_Z_TURN;
      end
      next_pair_sel = pair_sel;
      next_alert_en = alert_en;
      next_gain_cfg = gain_cfg;
      next_act_gain = act_gain;
      next_act_alert = act_alert;
      next_state = state;
      next_iter = iter;
      next_cx = cx;
      next_cy = cy;
      next_cz = cz;
      next_angle_result = angle_result;
      next_mag_result = mag_result;
      next_alert = 1'b0;
      set_int = 2'b00;
      clr_int = 2'b00;
      // register writes
      if (REG_WR) begin
         unique case (REG_ADDR)
            `AGT_A_ANG_CFG: begin
               next_pair_sel = REG_WDATA[`AGT_CFG_SEL];
               next_alert_en = REG_WDATA[`AGT_CFG_ALERT];
            end
            `AGT_A_GAIN_CFG: begin
               next_gain_cfg.value = REG_WDATA[`AGT_GAIN_VAL];
               next_gain_cfg.axis = REG_WDATA[`AGT_GAIN_AXIS];
            end
            `AGT_A_INT_STAT: clr_int = REG_WDATA[`AGT_INT_W];
            default: ;
         endcase
      end
      // calculator sequence
      unique case (state)
         AGT_IDLE: begin
            if (accept) begin
               next_act_gain = gain_cfg;
               next_act_alert = alert_en;
               next_iter = 4'h0;
               next_state = AGT_ITER;
               if (pa[15]) begin
                  next_cx = -{{3{pa[15]}}, pa};
                  next_cy = -{{3{pb[15]}}, pb};
                  next_cz = `AGT_Z_HALF;
               end else begin
                  next_cx = {{3{pa[15]}}, pa};
                  next_cy = {{3{pb[15]}}, pb};
                  next_cz = 18'h0_0000;
               end
            end
         end
         AGT_ITER: begin
            if (!cy[18]) begin
               next_cx = cx + dy;
               next_cy = cy - dx;
               next_cz = cz + $signed(atan_step(iter));
            end else begin
               next_cx = cx - dy;
               next_cy = cy + dx;
               next_cz = cz - $signed(atan_step(iter));
            end
            next_iter = iter + 4'h1;
            if (iter == `AGT_LAST_ITER) begin
               next_state = AGT_FIN;
            end
         end
         AGT_FIN: begin
            next_angle_result = {2'b00, zz[17:4]};
            next_mag_result = cx[17:2];
            next_alert = act_alert;
            set_int[`AGT_INT_DONE] = 1'b1;
            next_state = AGT_IDLE;
         end
      endcase
      set_int[`AGT_INT_OVR] = overrun;
      // a set in the clearing cycle survives
      next_int_status = (int_status & ~clr_int) | set_int;
      next_int_mask = int_mask;
      if (REG_WR && (REG_ADDR == `AGT_A_INT_MASK)) begin
         next_int_mask = REG_WDATA[`AGT_INT_W];
      end
      next_irq = |(next_int_status & next_int_mask);
   end

   // read data for the cycle after the read strobe
   always_comb begin
      next_rdata = 16'h0000;
      if (REG_RD) begin
         unique case (REG_ADDR)
            `AGT_A_ANG_CFG: next_rdata = {13'h0000, alert_en, pair_sel};
            `AGT_A_GAIN_CFG: next_rdata = {4'h0, gain_cfg};
            `AGT_A_ANGLE: next_rdata = angle_result;
            `AGT_A_MAG: next_rdata = mag_result;
            `AGT_A_INT_STAT: next_rdata = {14'h0000, int_status};
            `AGT_A_INT_MASK: next_rdata = {14'h0000, int_mask};
            `AGT_A_STATUS: next_rdata = {15'h0000, state != AGT_IDLE};
            default: next_rdata = 16'h0000;
         endcase
      end
   end

   // ********************************
   // registers
   // ********************************
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         {alert_en, pair_sel} <= `AGT_RST_CFG;
         gain_cfg <= `AGT_RST_GAIN;
         act_gain <= `AGT_RST_GAIN;
         act_alert <= 1'b0;
         state <= AGT_IDLE;
         iter <= 4'h0;
         cx <= 19'h0_0000;
         cy <= 19'h0_0000;
         cz <= 18'h0_0000;
         angle_result <= `AGT_RST_RES;
         mag_result <= `AGT_RST_RES;
         int_status <= `AGT_RST_INT;
         int_mask <= `AGT_RST_INT;
         REG_RDATA <= 16'h0000;
         ALERT <= 1'b0;
         IRQ <= 1'b0;
      end else begin
         pair_sel <= next_pair_sel;
         alert_en <= next_alert_en;
         gain_cfg <= next_gain_cfg;
         act_gain <= next_act_gain;
         act_alert <= next_act_alert;
         state <= next_state;
         iter <= next_iter;
         cx <= next_cx;
         cy <= next_cy;
         cz <= next_cz;
         angle_result <= next_angle_result;
         mag_result <= next_mag_result;
         int_status <= next_int_status;
         int_mask <= next_int_mask;
         REG_RDATA <= next_rdata;
         ALERT <= next_alert;
         IRQ <= next_irq;
      end
   end

   // ********************************
   // assertions
   // ********************************
   default clocking agt_cb @(posedge CLK);
   endclocking
   default disable iff (!RST_N);

   sequence s_start_alert;
      accept && alert_en;
   endsequence

   sequence s_alert_out;
      ##16 ALERT;
   endsequence

   AST_ALERT_LATENCY: assert property (
      s_start_alert |-> s_alert_out)
      else $error("alert missing sixteen cycles after start");

   AST_ALERT_CAUSE: assert property (
      ALERT |-> $past(state == AGT_FIN) && act_alert)
      else $error("alert without finished conversion");

   AST_RESULT_HOLD: assert property (
      $changed(angle_result) || $changed(mag_result)
      |-> $past(state == AGT_FIN))
      else $error("result changed outside conversion end");

   AST_RANGE: assert property (
      angle_result < `AGT_TURN16)
      else $error("angle reached a full turn");

   AST_FORMAT: assert property (
      angle_result[`AGT_DEG_FIELD] <= `AGT_MAX_DEG)
      else $error("whole degree field above 359");

   AST_PAIR: assert property (
      accept && (pair_sel == `AGT_PAIR_YZ)
      |=> (state == AGT_ITER) && (cz == 18'h0_0000 ?
          (cx[15:0] == $past(ty)) && (cy[15:0] == $past(SAMPLE.z)) :
          (cx[15:0] == -$past(ty)) && (cy[15:0] == -$past(SAMPLE.z))))
      else $error("angle operands not the selected axes");

   AST_TRIM_NONE: assert property (
      gain_cfg.axis == `AGT_TRIM_NONE
      |-> (tx == SAMPLE.x) && (ty == SAMPLE.y))
      else $error("trim applied while disabled");

   AST_TRIM_X: assert property (
      (gain_cfg.axis == `AGT_TRIM_X) && !SAMPLE.x[15]
      |-> (ty == SAMPLE.y) && (tx <= SAMPLE.x))
      else $error("x trim wrong axis or grew amplitude");

   AST_TRIM_Y: assert property (
      (gain_cfg.axis == `AGT_TRIM_Y) && !SAMPLE.y[15]
      |-> (tx == SAMPLE.x) && (ty <= SAMPLE.y))
      else $error("y trim wrong axis or grew amplitude");

   AST_TRIM_ZERO: assert property (
      (gain_cfg.axis == `AGT_TRIM_X) && (gain_cfg.value == 10'h000)
      |-> tx == 16'h0000)
      else $error("zero trim value left x nonzero");

   // the start edge itself loads the latched copy, so skip it
   AST_CFG_LATCH: assert property (
      (state != AGT_IDLE) && ($past(state) != AGT_IDLE)
      |-> $stable(act_gain))
      else $error("trim changed inside a conversion");

   AST_DONE_SET: assert property (
      (state == AGT_FIN) |=> int_status[`AGT_INT_DONE])
      else $error("done flag not set at conversion end");

endmodule : agt_angle_trim

// ===== verilog/agt_pkg.sv
// types shared by the angle and gain trim readout
// assumes agt_regs.svh supplies the numeric constants
package agt_pkg;

   // ********************************
   // carriers
   // ********************************
   typedef struct packed {
      logic signed [15:0] x;
      logic signed [15:0] y;
      logic signed [15:0] z;
   } agt_axes_t;

   typedef struct packed {
      logic [1:0] axis;
      logic [9:0] value;
   } agt_gain_t;

   typedef enum logic [1:0] {
      AGT_IDLE,
      AGT_ITER,
      AGT_FIN
   } agt_state_t;

endpackage : agt_pkg

// ===== verilog/agt_regs.svh
// register offsets, fields, reset values and counts of the angle block
// assumes a byte-address register port with 16-bit data
`ifndef AGT_REGS_SVH
`define AGT_REGS_SVH

// ********************************
// register offsets
// ********************************
`define AGT_A_ANG_CFG   8'h00
`define AGT_A_GAIN_CFG  8'h04
`define AGT_A_ANGLE     8'h08
`define AGT_A_MAG       8'h0C
`define AGT_A_INT_STAT  8'h10
`define AGT_A_INT_MASK  8'h14
`define AGT_A_STATUS    8'h18

// ********************************
// fields and codes
// ********************************
`define AGT_CFG_SEL     1:0
`define AGT_CFG_ALERT   2
`define AGT_GAIN_VAL    9:0
`define AGT_GAIN_AXIS   11:10
`define AGT_PAIR_XY     2'b00
`define AGT_PAIR_YZ     2'b01
`define AGT_PAIR_XZ     2'b10
`define AGT_TRIM_NONE   2'b00
`define AGT_TRIM_X      2'b01
`define AGT_TRIM_Y      2'b10
`define AGT_INT_DONE    0
`define AGT_INT_OVR     1
`define AGT_INT_W       1:0

// ********************************
// reset values and counts
// ********************************
`define AGT_RST_CFG     3'h0
`define AGT_RST_GAIN    12'h000
`define AGT_RST_RES     16'h0000
`define AGT_RST_INT     2'h0
`define AGT_LAST_ITER   4'hD
`define AGT_TRIM_SHIFT  10
`define AGT_Z_HALF      18'h0_B400
`define AGT_Z_TURN      18'h1_6800
`define AGT_TURN16      16'h1680
`define AGT_MAX_DEG     12'h167
`define AGT_DEG_FIELD   15:4

`endif
